// ---- test/rsl_strap_board.sv ----
// Strap resistor model for the shared address/data lines.
// Assumes the bench supplies the strap pattern and the system reset.
`default_nettype none
module rsl_strap_board (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] straps,
    output logic [31:26] pci_ad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] traffic_q;

    // Other agents toggle the lines every cycle once reset is over
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            traffic_q <= 6'h2a;
        end else begin
            traffic_q <= traffic_q + 6'h15;
        end
    end

    // Resistors set the level in reset; PLL bit low only for bypass
    assign pci_ad = rst_n ? (traffic_q ^ ~straps) : straps;
endmodule
`default_nettype wire

// ---- test/rsl_top_test.sv ----
// Bench for the reset strap latch: capture, decode, status, stream.
// Assumes rsl_pkg, rsl_top and the strap board model compile first.
`default_nettype none
module rsl_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import rsl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] straps = 6'h00;
    logic [31:26] pci_ad;
    logic cfg_sel = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [31:0] cfg_rdata;
    logic cfg_rvalid;
    rsl_rate_t rate;
    rsl_len_t len;
    logic rsvd, pll, range_hi, stream, valid, done;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    // Every rate code and every length code, mixed enables
    logic [5:0] strap_set [4] = '{6'h08, 6'h15, 6'h2e, 6'h33};

    rsl_top u_rsl_top (.clk(clk), .rst_n(rst_n), .pci_ad(pci_ad),
        .cfg_sel(cfg_sel), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .bus_clock_rate_strap(rate), .bus_clock_rate_reserved(rsvd),
        .pll_run_strap(pll), .clock_receiver_range_strap(range_hi),
        .bus_length_strap(len), .init_param_stream(stream),
        .init_param_valid(valid), .init_param_done(done));
    rsl_strap_board u_rsl_strap_board (.clk(clk), .rst_n(rst_n),
        .straps(straps), .pci_ad(pci_ad));

    // ****************************************
    // Clock, watchdog and verdict
    // ****************************************
    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            results();
        end
    end

    task automatic results();
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Reset for 12 cycles; a wrong pattern first, the real one last
    task automatic do_reset(input logic [5:0] s);
        rst_n = 1'b0;
        straps = ~s;
        repeat (6) @(negedge clk);
        straps = s;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
    endtask

    // One read with a one-cycle answer
    task automatic read_reg(input logic sel, input logic [7:0] addr,
                            input logic [31:0] exp);
        cfg_sel = sel;
        cfg_addr = addr;
        cfg_rd = 1'b1;
        @(negedge clk);
        check({31'h0, cfg_rvalid}, 32'h1);
        check(cfg_rdata, exp);
        cfg_rd = 1'b0;
        cfg_sel = 1'b0;
        @(negedge clk);
        check({31'h0, cfg_rvalid}, 32'h0);
    endtask

    // Stream starts on the 2nd edge, 10 cycles per bit, MSB first
    task automatic check_stream(input logic [5:0] s);
        logic [7:0] word;
        int k;
        word = {s, 2'b00};
        k = 0;
        while (valid !== 1'b1 && k < 6) begin
            @(negedge clk);
            k++;
        end
        check(k, 2);
        for (int b = 7; b >= 0; b--) begin
            repeat (5) @(negedge clk);
            check({30'h0, valid, stream}, {30'h0, 1'b1, word[b]});
            repeat (5) @(negedge clk);
        end
        check({30'h0, valid, done}, 32'h1);
    endtask

    // Decoded outputs after long bus traffic still match the straps
    task automatic check_straps(input logic [5:0] s);
        check({30'h0, rate}, {30'h0, s[5:4]});
        check({31'h0, pll}, {31'h0, s[3]});
        check({31'h0, range_hi}, {31'h0, s[2]});
        check({30'h0, len}, {30'h0, s[1:0]});
        check({31'h0, rsvd}, {31'h0, s[5:4] == 2'b10});
    endtask

    task automatic run_case(input logic [5:0] s);
        do_reset(s);
        check_stream(s);
        check_straps(s);
        read_reg(1'b1, RSL_STATUS_OFFSET, {s, 26'h0});
        read_reg(1'b1, 8'h8c, 32'h0);
        read_reg(1'b0, RSL_STATUS_OFFSET, 32'h0);
        read_reg(1'b1, RSL_STATUS_OFFSET, {s, 26'h0});
        @(negedge clk);
        check({31'h0, cfg_rvalid}, 32'h0);
    endtask

    initial begin
        for (int i = 0; i < 4; i++) begin
            run_case(strap_set[i]);
        end
        results();
    end
endmodule
`default_nettype wire

// ---- verilog/rsl_cfg_if.sv ----
// Carries latched strap settings from the latch to the serializer.
// Assumes both ends share the core clock.
`default_nettype none
interface rsl_cfg_if;
    import rsl_pkg::*;
    rsl_rate_t rate;
    logic pll_run;
    logic range_hi;
    rsl_len_t len;
    logic go;
    modport src (output rate, pll_run, range_hi, len, go);
    modport dst (input rate, pll_run, range_hi, len, go);
endinterface
`default_nettype wire

// ---- verilog/rsl_pkg.sv ----
// Constants and types shared by the reset strap latch and its serializer.
// Assumes one 100 MHz core clock and a synchronous active-low reset.
// Operation
// - Sample strap lines while reset is active.
// - Latched high enables, low disables option.
// - Rate strap: 100, 66 test, reserved, 133.
// - Latched straps readable at status offset 0x88.
// - Range strap picks low or high threshold.
// - Length strap: short, close, far, farthest.
// - Straps form the post-reset parameter stream.
`default_nettype none
package rsl_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] RSL_STATUS_OFFSET = 8'h88;
    localparam logic [31:0] RSL_STATUS_RESET = 32'h0000_0000;
    // Field positions inside the status word
    localparam int RSL_RATE_LSB = 30;
    localparam int RSL_PLL_BIT = 29;
    localparam int RSL_RANGE_BIT = 28;
    localparam int RSL_LEN_LSB = 26;
    // Unused value for the latched strap bits [31:26]; the strap register has no reset
    localparam logic [5:0] RSL_STRAP_RESET = 6'h00;

    // ****************************************
    // Stream timing
    // ****************************************
    localparam int RSL_CLK_PERIOD_NS = 10;
    localparam int RSL_STREAM_BIT_NS = 100;
    localparam int RSL_BIT_CYCLES = RSL_STREAM_BIT_NS / RSL_CLK_PERIOD_NS;
    localparam int RSL_STREAM_BITS = 8;

    // ****************************************
    // Decoded strap types
    // ****************************************
    typedef enum logic [1:0] {
        RSL_RATE_100 = 2'b00,
        RSL_RATE_66 = 2'b01,
        RSL_RATE_RSVD = 2'b10,
        RSL_RATE_133 = 2'b11
    } rsl_rate_t;

    typedef enum logic [1:0] {
        RSL_LEN_SHORT = 2'b00,
        RSL_LEN_CLOSE = 2'b01,
        RSL_LEN_FAR = 2'b10,
        RSL_LEN_FARTHEST = 2'b11
    } rsl_len_t;

    // Packs the decoded straps into the parameter stream word
    function automatic logic [7:0] rsl_stream_word(
        input rsl_rate_t rate,
        input logic pll_run,
        input logic range_hi,
        input rsl_len_t len
    );
        rsl_stream_word = {rate, pll_run, range_hi, len, 2'b00};
    endfunction
endpackage
`default_nettype wire

// ---- verilog/rsl_stream.sv ----
// Serializes the latched straps into the parameter stream after reset.
// Assumes go pulses once, one cycle after reset release.
`default_nettype none
module rsl_stream (
    input wire logic clk,
    input wire logic rst_n,
    rsl_cfg_if.dst cfg,
    output logic init_param_stream,
    output logic init_param_valid,
    output logic init_param_done
);
    import rsl_pkg::*;

    // ****************************************
    // Shift state
    // ****************************************
    typedef enum logic [1:0] {
        RSL_ST_IDLE = 2'b00,
        RSL_ST_SHIFT = 2'b01,
        RSL_ST_DONE = 2'b10
    } rsl_state_t;

    rsl_state_t state_q, state_d;
    logic [7:0] word_q, word_d;
    logic [3:0] div_q, div_d;
    logic [3:0] bits_q, bits_d;
    logic tick;

    // Bit-rate enable from the divider
    assign tick = (div_q == 4'(RSL_BIT_CYCLES - 1));

    // Next state of the shifter
    always_comb begin
        state_d = state_q;
        word_d = word_q;
        div_d = div_q;
        bits_d = bits_q;
        unique case (state_q)
            RSL_ST_IDLE: begin
                if (cfg.go) begin
                    word_d = rsl_stream_word(cfg.rate, cfg.pll_run,
                        cfg.range_hi, cfg.len);
                    div_d = 4'h0;
                    bits_d = 4'h0;
                    state_d = RSL_ST_SHIFT;
                end
            end
            RSL_ST_SHIFT: begin
                div_d = tick ? 4'h0 : div_q + 4'h1;
                if (tick) begin
                    word_d = {word_q[6:0], 1'b0};
                    bits_d = bits_q + 4'h1;
                    if (bits_q == 4'(RSL_STREAM_BITS - 1)) begin
                        state_d = RSL_ST_DONE;
                    end
                end
            end
            RSL_ST_DONE: begin
                state_d = RSL_ST_DONE;
            end
            default: begin
                state_d = RSL_ST_IDLE;
            end
        endcase
    end

    // Registers of the shifter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= RSL_ST_IDLE;
            word_q <= 8'h00;
            div_q <= 4'h0;
            bits_q <= 4'h0;
        end else begin
            state_q <= state_d;
            word_q <= word_d;
            div_q <= div_d;
            bits_q <= bits_d;
        end
    end

    assign init_param_stream = word_q[7];
    assign init_param_valid = (state_q == RSL_ST_SHIFT);
    assign init_param_done = (state_q == RSL_ST_DONE);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_stream_load: assert property (
        (state_q == RSL_ST_IDLE) && cfg.go |=> init_param_valid &&
        word_q == rsl_stream_word(cfg.rate, cfg.pll_run, cfg.range_hi,
        cfg.len)) else $error("stream did not load straps");
    chk_stream_ends: assert property (
        $rose(init_param_valid) |-> ##[79:81] init_param_done)
        else $error("stream length wrong");
    cov_stream_done: cover property ($rose(init_param_done));
endmodule
`default_nettype wire

// ---- verilog/rsl_top.sv ----
// Reset strap latch: captures board straps on the shared address/data
// lines during reset, decodes them and shows them in a status register.
// Assumes strap resistors hold the lines steady while reset is low.
`default_nettype none
module rsl_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:26] pci_ad,
    input wire logic cfg_sel,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    output rsl_pkg::rsl_rate_t bus_clock_rate_strap,
    output logic bus_clock_rate_reserved,
    output logic pll_run_strap,
    output logic clock_receiver_range_strap,
    output rsl_pkg::rsl_len_t bus_length_strap,
    output logic init_param_stream,
    output logic init_param_valid,
    output logic init_param_done
);
    import rsl_pkg::*;

    // ****************************************
    // Strap capture
    // ****************************************
    logic [5:0] strap_q, strap_d;
    logic rel_q, rel_d;
    logic go_q, go_d;
    logic [31:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] status;
    logic hit;

    // Follow the lines during reset, freeze from release onward
    always_comb begin
        strap_d = rst_n ? strap_q : pci_ad;
        rel_d = 1'b1;
        go_d = !rel_q;
    end

    // Strap register has no reset value: reset time is when it samples
    // the pins. Release and start flags clear in reset.
    always_ff @(posedge clk) begin
        strap_q <= strap_d;
        if (!rst_n) begin
            rel_q <= 1'b0;
            go_q <= 1'b0;
        end else begin
            rel_q <= rel_d;
            go_q <= go_d;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    // Rate and length keep their own codes, single bits are enables.
    // Reserved rate code is flagged, not remapped, so firmware sees
    // exactly what the board strapped.
    assign bus_clock_rate_strap =
        rsl_rate_t'(strap_q[RSL_RATE_LSB - 26 +: 2]);
    assign bus_clock_rate_reserved =
        (bus_clock_rate_strap == RSL_RATE_RSVD);
    assign pll_run_strap = strap_q[RSL_PLL_BIT - 26];
    assign clock_receiver_range_strap =
        strap_q[RSL_RANGE_BIT - 26];
    assign bus_length_strap =
        rsl_len_t'(strap_q[RSL_LEN_LSB - 26 +: 2]);

    // ****************************************
    // Status register read port
    // ****************************************
    // Status word mirrors strap positions, other bits read zero
    always_comb begin
        status = RSL_STATUS_RESET;
        status[31:26] = strap_q;
    end

    assign hit = cfg_sel && (cfg_addr == RSL_STATUS_OFFSET);

    // Answer one cycle after the read, zero for other offsets
    always_comb begin
        rvalid_d = cfg_rd;
        rdata_d = rdata_q;
        if (cfg_rd) begin
            rdata_d = hit ? status : 32'h0000_0000;
        end
    end

    // Read data registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_rvalid = rvalid_q;

    // ****************************************
    // Parameter stream
    // ****************************************
    rsl_cfg_if cfg_link ();

    // Hand latched settings to the serializer, start once per reset
    assign cfg_link.rate = bus_clock_rate_strap;
    assign cfg_link.pll_run = pll_run_strap;
    assign cfg_link.range_hi = clock_receiver_range_strap;
    assign cfg_link.len = bus_length_strap;
    assign cfg_link.go = go_q;

    rsl_stream u_stream (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg_link),
        .init_param_stream(init_param_stream),
        .init_param_valid(init_param_valid),
        .init_param_done(init_param_done)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Capture and decode: every field follows the last reset sample
    chk_capture_at_release: assert property (
        $rose(rst_n) |-> strap_q == $past(pci_ad))
        else $error("strap not captured from reset");
    chk_hold_after_release: assert property (
        $past(rst_n) |-> $stable(strap_q))
        else $error("strap changed after release");
    chk_rate_decode: assert property (
        $rose(rst_n) && $past(pci_ad[31:30]) == 2'b11 |->
        bus_clock_rate_strap == RSL_RATE_133 && !bus_clock_rate_reserved)
        else $error("rate decode wrong");
    chk_pll_level: assert property (
        $rose(rst_n) |-> pll_run_strap == $past(pci_ad[29]))
        else $error("pll strap level wrong");
    chk_range_level: assert property (
        $rose(rst_n) |-> clock_receiver_range_strap == $past(pci_ad[28]))
        else $error("range strap wrong");
    chk_len_decode: assert property (
        $rose(rst_n) |-> bus_length_strap == rsl_len_t'($past(pci_ad[27:26])))
        else $error("length decode wrong");
    chk_rate_all_codes: assert property (
        $rose(rst_n) |->
        bus_clock_rate_strap == rsl_rate_t'($past(pci_ad[31:30])))
        else $error("rate code not kept");
    chk_rate_base_code: assert property (
        $rose(rst_n) && $past(pci_ad[31:30]) == 2'b00 |->
        bus_clock_rate_strap == RSL_RATE_100 && !bus_clock_rate_reserved)
        else $error("base rate decode wrong");
    chk_rate_reserved: assert property (
        $rose(rst_n) && $past(pci_ad[31:30]) == 2'b10 |->
        bus_clock_rate_reserved && bus_clock_rate_strap == RSL_RATE_RSVD)
        else $error("reserved rate not flagged");
    chk_len_far_code: assert property (
        $rose(rst_n) && $past(pci_ad[27:26]) == 2'b10 |->
        bus_length_strap == RSL_LEN_FAR)
        else $error("far length decode wrong");
    // Later traffic on the shared lines must not reach any field
    chk_decode_hold: assert property (
        $past(rst_n) |-> $stable(bus_clock_rate_strap) &&
        $stable(pll_run_strap) && $stable(clock_receiver_range_strap) &&
        $stable(bus_length_strap))
        else $error("decoded strap moved after release");
    chk_status_hold: assert property (
        $past(rst_n) |-> $stable(status))
        else $error("status word moved after release");

    // Read port: one answer per strobe, data held between reads
    chk_status_read: assert property (
        cfg_rd && hit |=> cfg_rvalid && cfg_rdata[31:26] == strap_q &&
        cfg_rdata[25:0] == 26'h0) else $error("status read wrong");
    chk_unmapped_zero: assert property (
        cfg_rd && !hit |=> cfg_rvalid && cfg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_read_pulse: assert property (
        !cfg_rd |=> !cfg_rvalid)
        else $error("answer without a read");
    chk_rvalid_after_read: assert property (
        cfg_rd |=> cfg_rvalid)
        else $error("read not answered");
    chk_rdata_hold: assert property (
        !cfg_rd |=> $stable(cfg_rdata))
        else $error("read data moved between reads");
    chk_status_field_map: assert property (
        cfg_rd && hit |=> cfg_rdata[31:30] == bus_clock_rate_strap &&
        cfg_rdata[29] == pll_run_strap &&
        cfg_rdata[28] == clock_receiver_range_strap &&
        cfg_rdata[27:26] == bus_length_strap)
        else $error("status field out of place");

    // Parameter stream: one run per reset, first bit is the rate MSB
    chk_stream_start: assert property (
        $rose(rst_n) |-> ##2 init_param_valid)
        else $error("stream did not start");
    chk_go_once: assert property (
        go_q |=> !go_q)
        else $error("stream start repeated");
    chk_stream_first_bit: assert property (
        $rose(init_param_valid) |-> init_param_stream == strap_q[5])
        else $error("stream first bit wrong");
    chk_done_stays: assert property (
        init_param_done |=> init_param_done)
        else $error("done dropped before reset");
    chk_valid_done_apart: assert property (
        !(init_param_valid && init_param_done))
        else $error("valid and done overlap");

    cov_read_hit: cover property (cfg_rd && hit);
    cov_rate_133: cover property (bus_clock_rate_strap == RSL_RATE_133);
    cov_rate_rsvd: cover property (bus_clock_rate_reserved);
    cov_len_farthest: cover property (bus_length_strap == RSL_LEN_FARTHEST);
endmodule
`default_nettype wire
